/* nep_map.svh */
// Purpose: Constants of the page ECC engine: page layout, codes, feature bits, timing
// Assumes: 2KB main page plus 128 spare bytes, byte-wide cache, 100 MHz core clock
// Notes: Each sector is 512 main bytes plus 16 spare bytes, guarded by 11 code bytes in its 16 parity bytes
// Notes on behaviour
// (RULE_01) Correct up to eight bit errors per sector; code corrects at most one per bit lane, two in one lane are uncorrectable
// (RULE_02) ECC active straight after power up
// (RULE_03) Feature write B0h bit 4 toggles ECC
// (RULE_04) Program computes check bits into hidden spare
// (RULE_05) Read recomputes, compares, outputs corrected data only
// (RULE_06) Main 000h-7FFh and spare to 83Fh protected
// (RULE_07) Main n pairs with spare n per sector
// (RULE_08) Parity regions 840h-87Fh in sector order
// (RULE_09) Host: at most four partial programs per page
// (RULE_10) Host: program each area only once
// (RULE_11) Result codes 000, 001, 011, 101 by count
// (RULE_12) More than eight errors gives 010
// (RULE_13) Result bit 0 set for corrected errors
// (RULE_14) Host ignores result after disabling, then resets
// (RULE_15) Power-up loads page 0 into cache
// (RULE_16) Host waits 2 ms before first command
// (RULE_17) Result cleared on reset or read start
// (RULE_18) Result shown in status bits 6 to 4
// (RULE_19) ECC off: data passes through unmodified
`ifndef NEP_MAP_SVH
`define NEP_MAP_SVH

`define NEP_PAGE_LAST       12'h87F
`define NEP_MAIN_BYTES      12'h200
`define NEP_SPARE_BASE      12'h800
`define NEP_PARITY_BASE     12'h840
`define NEP_PARITY_LAST     12'h00F
`define NEP_SECTOR_LAST     12'h20F
`define NEP_CODE_LAST       12'h00A
`define NEP_SECTOR_COUNT_M1 2'h3

`define NEP_FIRST_POS       10'h003
`define NEP_LAST_POS        10'h21A

`define NEP_CFG_ADDR        8'hB0
`define NEP_CFG_ECC_BIT     4
`define NEP_ECC_RESET       1'b1

`define NEP_RES_CLEAN       3'h0
`define NEP_RES_LOW         3'h1
`define NEP_RES_UNCORR      3'h2
`define NEP_RES_MID         3'h3
`define NEP_RES_HIGH        3'h5
`define NEP_LOW_MAX         4'h3
`define NEP_MID_MAX         4'h6

`define NEP_CLK_PERIOD_NS   10
`define NEP_PWR_UP_WAIT_NS  2000000
`define NEP_PWR_UP_WAIT_CYC (`NEP_PWR_UP_WAIT_NS / `NEP_CLK_PERIOD_NS)

`endif

/* nep_pkg.sv */
// Purpose: Types shared by the page ECC engine files
// Assumes: Column addresses fit in twelve bits
// Notes: Constants live in nep_map.svh
`default_nettype none
package nep_pkg;
	typedef logic [11:0] nep_col_t;
	typedef logic [9:0]  nep_pos_t;
	typedef logic [2:0]  nep_result_t;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_LOAD   = 4'h1,
		ST_SCAN   = 4'h2,
		ST_PGET   = 4'h3,
		ST_ABSORB = 4'h4,
		ST_EVAL   = 4'h5,
		ST_FIX    = 4'h6,
		ST_PPUT   = 4'h7,
		ST_STORE  = 4'h8
	} nep_state_e;
endpackage
`default_nettype wire

/* nep_cache_mem.sv */
// Purpose: Cache register of one page, single port, registered read data
// Assumes: One access per cycle
// Notes: Read data appears one cycle after the address
`default_nettype none
module nep_cache_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2176,
	parameter int AW    = 12
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             srst,
	// Access port
	input  wire logic [AW-1:0]    addr,
	input  wire logic             wrEn,
	input  wire logic [WIDTH-1:0] wrData,
	output logic      [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdData_reg;

	always_ff @(posedge core_clk) begin
		if (wrEn && (int'(addr) < DEPTH)) begin
			mem[addr] <= wrData;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdData_reg <= '0;
		end else if (int'(addr) < DEPTH) begin
			rdData_reg <= mem[addr];
		end else begin
			rdData_reg <= '0;
		end
	end

	assign rdData = rdData_reg;
endmodule
`default_nettype wire

/* nep_ecc_lane.sv */
// Purpose: One bit lane of a sector code: extended Hamming syndrome over 528 bits
// Assumes: Caller feeds data bits with their code positions, check bits sit at powers of two
// Notes: Eight lanes side by side handle one error in each lane of a sector
`default_nettype none
`include "nep_map.svh"
module nep_ecc_lane (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              srst,
	// Accumulation control
	input  wire logic              clr,
	input  wire logic              acc,
	input  wire logic              dataBit,
	input  wire nep_pkg::nep_pos_t pos,
	input  wire logic              absorb,
	input  wire nep_pkg::nep_pos_t storedChk,
	input  wire logic              storedPar,
	// Code word and verdict
	output nep_pkg::nep_pos_t      codeChk,
	output logic                   codePar,
	output logic                   corrected,
	output logic                   fixData,
	output logic                   uncorrectable
);
	import nep_pkg::*;

	nep_pos_t synPos_reg;
	nep_pos_t synPos_next;
	logic     synPar_reg;
	logic     synPar_next;
	logic     isPow2;

	always_comb begin
		synPos_next = synPos_reg;
		synPar_next = synPar_reg;
		if (clr) begin
			synPos_next = '0;
			synPar_next = 1'b0;
		end else if (acc && dataBit) begin
			synPos_next = synPos_reg ^ pos;
			synPar_next = ~synPar_reg;
		end else if (absorb) begin
			// Overall parity also covers the stored check bits
			synPos_next = synPos_reg ^ storedChk;
			synPar_next = synPar_reg ^ storedPar ^ (^storedChk);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			synPos_reg <= '0;
			synPar_reg <= 1'b0;
		end else begin
			synPos_reg <= synPos_next;
			synPar_reg <= synPar_next;
		end
	end

	assign isPow2        = (synPos_reg & (synPos_reg - 10'h001)) == 10'h000;
	assign codeChk       = synPos_reg;
	assign codePar       = synPar_reg ^ (^synPos_reg);
	assign corrected     = synPar_reg && (synPos_reg <= `NEP_LAST_POS);
	assign fixData       = corrected && (synPos_reg != 10'h000) && !isPow2;
	assign uncorrectable = (!synPar_reg && (synPos_reg != 10'h000)) || (synPar_reg && (synPos_reg > `NEP_LAST_POS));
endmodule
`default_nettype wire

/* nep_ecc_engine.sv */
// Purpose: Page ECC engine of a serial NAND: array/cache moves, encode on program, correct on read
// Assumes: Array port returns read data one cycle after arrayRdEn; front end decodes commands
// Notes: Eight interleaved lanes per sector, one corrected bit per lane per sector
`default_nettype none
`include "nep_map.svh"
module nep_ecc_engine #(
	parameter int ROW_W             = 17,
	parameter int POWER_UP_WAIT_CYC = `NEP_PWR_UP_WAIT_CYC
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              srst,
	// Commands from the serial front end
	input  wire logic              pageReadReq,
	input  wire logic              programReq,
	input  wire logic [ROW_W-1:0]  pageRow,
	input  wire logic              cmdReset,
	// Feature access
	input  wire logic              cfgWrEn,
	input  wire logic [7:0]        cfgAddr,
	input  wire logic [7:0]        cfgWrData,
	output logic                   eccEnable,
	output logic [7:0]             statusByte,
	output logic                   correctionResultBit2,
	output logic                   correctionResultBit1,
	output logic                   correctionResultBit0,
	output logic                   busy,
	output logic                   opDone,
	// Cache port for the front end
	input  wire nep_pkg::nep_col_t hostAddr,
	input  wire logic              hostWrEn,
	input  wire logic [7:0]        hostWrData,
	output logic [7:0]             hostRdData,
	// Array port
	output logic [ROW_W-1:0]       arrayRow,
	output nep_pkg::nep_col_t      arrayAddr,
	output logic                   arrayRdEn,
	input  wire logic [7:0]        arrayRdData,
	output logic                   arrayWrEn,
	output logic [7:0]             arrayWrData
);
	import nep_pkg::*;

	function automatic nep_col_t secAddr(input nep_col_t idx, input logic [1:0] sec);
		// (RULE_06) main and spare covered
		if (idx < `NEP_MAIN_BYTES) begin
			secAddr = {1'b0, sec, idx[8:0]};
		end else begin
			// (RULE_07) spare n joins main n
			secAddr = `NEP_SPARE_BASE | {6'h00, sec, idx[3:0]};
		end
	endfunction

	function automatic nep_pos_t nextPos(input nep_pos_t p);
		nep_pos_t n;
		n = p + 10'h001;
		// Powers of two hold check bits
		if ((n & (n - 10'h001)) == 10'h000) begin
			n = n + 10'h001;
		end
		return n;
	endfunction

	function automatic logic [3:0] popCount(input logic [7:0] v);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < 8; i++) begin
			c = c + {3'h0, v[i]};
		end
		return c;
	endfunction

	nep_state_e        state_reg,   state_next;
	nep_col_t          cnt_reg,     cnt_next;
	logic              phase_reg,   phase_next;
	logic [1:0]        sector_reg,  sector_next;
	nep_pos_t          pos_reg,     pos_next;
	logic              opEcc_reg,   opEcc_next;
	logic              opRead_reg,  opRead_next;
	logic [ROW_W-1:0]  row_reg,     row_next;
	logic              ecc_reg,     ecc_next;
	nep_result_t       result_reg,  result_next;
	logic [3:0]        worst_reg,   worst_next;
	logic              uncorr_reg,  uncorr_next;
	logic [87:0]       stored_reg,  stored_next;
	logic [17:0]       initCnt_reg, initCnt_next;
	logic              done_reg,    done_next;

	nep_col_t          memAddr;
	logic              memWe;
	logic [7:0]        memWrData;
	logic [7:0]        memRdData;
	logic              laneClr;
	logic              laneAcc;
	logic              laneAbsorb;
	logic [87:0]       codeVec;
	logic [127:0]      codeWide;
	logic [7:0]        laneCorr;
	logic [7:0]        laneFix;
	logic [7:0]        laneUnc;
	logic [7:0]        fixMask;
	logic [3:0]        secCount;
	logic              finish;
	logic              readStart;

	nep_cache_mem #(
		.WIDTH (8),
		.DEPTH (2176),
		.AW    (12)
	) u_cache (
		.core_clk (core_clk),
		.srst     (srst),
		.addr     (memAddr),
		.wrEn     (memWe),
		.wrData   (memWrData),
		.rdData   (memRdData)
	);

	// (RULE_01) one lane per bit of a byte
	for (genvar j = 0; j < 8; j++) begin : g_lane
		nep_pos_t chk;
		logic     par;
		nep_ecc_lane u_lane (
			.core_clk      (core_clk),
			.srst          (srst),
			.clr           (laneClr),
			.acc           (laneAcc),
			.dataBit       (memRdData[j]),
			.pos           (pos_reg),
			.absorb        (laneAbsorb),
			.storedChk     (stored_reg[11*j +: 10]),
			.storedPar     (stored_reg[11*j + 10]),
			.codeChk       (chk),
			.codePar       (par),
			.corrected     (laneCorr[j]),
			.fixData       (laneFix[j]),
			.uncorrectable (laneUnc[j])
		);
		assign codeVec[11*j +: 11] = {par, chk};
		assign fixMask[j]          = laneFix[j] && (chk == pos_reg);
	end

	assign codeWide = {40'h0, codeVec};
	assign secCount = popCount(laneCorr);

	// Datapath strobes follow the state
	always_comb begin
		memAddr    = hostAddr;
		memWe      = 1'b0;
		memWrData  = hostWrData;
		arrayRdEn  = 1'b0;
		arrayWrEn  = 1'b0;
		laneClr    = 1'b0;
		laneAcc    = 1'b0;
		laneAbsorb = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				memWe = hostWrEn && (initCnt_reg == 18'h0);
			end
			ST_LOAD: begin
				memAddr   = cnt_reg;
				arrayRdEn = !phase_reg;
				memWe     = phase_reg;
				memWrData = arrayRdData;
			end
			ST_SCAN: begin
				memAddr = secAddr(cnt_reg, sector_reg);
				laneClr = !phase_reg && (cnt_reg == 12'h000);
				laneAcc = phase_reg;
			end
			ST_PGET: begin
				memAddr = `NEP_PARITY_BASE | {6'h00, sector_reg, cnt_reg[3:0]};
			end
			ST_ABSORB: begin
				laneAbsorb = 1'b1;
			end
			ST_EVAL: begin
				memAddr = hostAddr;
			end
			ST_FIX: begin
				// (RULE_05) flip erroneous bits in cache
				memAddr   = secAddr(cnt_reg, sector_reg);
				memWe     = phase_reg && (fixMask != 8'h00);
				memWrData = memRdData ^ fixMask;
			end
			ST_PPUT: begin
				// (RULE_08) parity region per sector
				memAddr   = `NEP_PARITY_BASE | {6'h00, sector_reg, cnt_reg[3:0]};
				memWe     = 1'b1;
				memWrData = (cnt_reg <= `NEP_CODE_LAST) ? codeWide[{cnt_reg[3:0], 3'h0} +: 8] : 8'h00;
			end
			ST_STORE: begin
				memAddr   = cnt_reg;
				arrayWrEn = phase_reg;
			end
		endcase
	end

	assign readStart = (state_reg == ST_IDLE) && !busy && pageReadReq;

	// Sequencing of page moves and sector passes
	always_comb begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		phase_next   = ~phase_reg;
		sector_next  = sector_reg;
		pos_next     = pos_reg;
		opEcc_next   = opEcc_reg;
		opRead_next  = opRead_reg;
		row_next     = row_reg;
		worst_next   = worst_reg;
		uncorr_next  = uncorr_reg;
		stored_next  = stored_reg;
		finish       = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				phase_next = 1'b0;
				cnt_next   = 12'h000;
				if (!busy && (pageReadReq || programReq)) begin
					row_next    = pageRow;
					opEcc_next  = ecc_reg;
					opRead_next = pageReadReq;
					sector_next = 2'h0;
					pos_next    = `NEP_FIRST_POS;
					worst_next  = 4'h0;
					uncorr_next = 1'b0;
					// (RULE_19) no encode with ECC off
					if (pageReadReq) begin
						state_next = ST_LOAD;
					end else if (ecc_reg) begin
						state_next = ST_SCAN;
					end else begin
						state_next = ST_STORE;
					end
				end
			end
			ST_LOAD: begin
				if (phase_reg) begin
					cnt_next = cnt_reg + 12'h001;
					if (cnt_reg == `NEP_PAGE_LAST) begin
						cnt_next = 12'h000;
						// (RULE_19) plain copy with ECC off
						if (opEcc_reg) begin
							state_next = ST_SCAN;
						end else begin
							finish = 1'b1;
						end
					end
				end
			end
			ST_SCAN: begin
				if (phase_reg) begin
					pos_next = nextPos(pos_reg);
					cnt_next = cnt_reg + 12'h001;
					if (cnt_reg == `NEP_SECTOR_LAST) begin
						cnt_next   = 12'h000;
						// (RULE_05) recompute then compare
						state_next = opRead_reg ? ST_PGET : ST_PPUT;
					end
				end
			end
			ST_PGET: begin
				if (phase_reg) begin
					stored_next = {memRdData, stored_reg[87:8]};
					cnt_next    = cnt_reg + 12'h001;
					if (cnt_reg == `NEP_CODE_LAST) begin
						cnt_next   = 12'h000;
						state_next = ST_ABSORB;
					end
				end
			end
			ST_ABSORB: begin
				phase_next = 1'b0;
				state_next = ST_EVAL;
			end
			ST_EVAL: begin
				phase_next = 1'b0;
				pos_next   = `NEP_FIRST_POS;
				// (RULE_12) any lane beyond reach
				if (laneUnc != 8'h00) begin
					uncorr_next = 1'b1;
				end
				if (secCount > worst_reg) begin
					worst_next = secCount;
				end
				if ((laneFix != 8'h00) && (laneUnc == 8'h00)) begin
					state_next = ST_FIX;
				end else if (sector_reg == `NEP_SECTOR_COUNT_M1) begin
					finish = 1'b1;
				end else begin
					sector_next = sector_reg + 2'h1;
					state_next  = ST_SCAN;
				end
			end
			ST_FIX: begin
				if (phase_reg) begin
					pos_next = nextPos(pos_reg);
					cnt_next = cnt_reg + 12'h001;
					if (cnt_reg == `NEP_SECTOR_LAST) begin
						cnt_next = 12'h000;
						pos_next = `NEP_FIRST_POS;
						if (sector_reg == `NEP_SECTOR_COUNT_M1) begin
							finish = 1'b1;
						end else begin
							sector_next = sector_reg + 2'h1;
							state_next  = ST_SCAN;
						end
					end
				end
			end
			ST_PPUT: begin
				// (RULE_04) check bits before array write
				phase_next = 1'b0;
				cnt_next   = cnt_reg + 12'h001;
				if (cnt_reg == `NEP_PARITY_LAST) begin
					cnt_next = 12'h000;
					pos_next = `NEP_FIRST_POS;
					if (sector_reg == `NEP_SECTOR_COUNT_M1) begin
						state_next = ST_STORE;
					end else begin
						sector_next = sector_reg + 2'h1;
						state_next  = ST_SCAN;
					end
				end
			end
			ST_STORE: begin
				if (phase_reg) begin
					cnt_next = cnt_reg + 12'h001;
					if (cnt_reg == `NEP_PAGE_LAST) begin
						cnt_next = 12'h000;
						finish   = 1'b1;
					end
				end
			end
		endcase
		if (finish) begin
			state_next = ST_IDLE;
			phase_next = 1'b0;
		end
	end

	// Feature bit, result and power-up timer
	always_comb begin
		ecc_next     = ecc_reg;
		result_next  = result_reg;
		initCnt_next = (initCnt_reg != 18'h0) ? initCnt_reg - 18'h1 : initCnt_reg;
		done_next    = finish;
		// (RULE_03) feature write at B0h bit 4
		if (cfgWrEn && (cfgAddr == `NEP_CFG_ADDR)) begin
			ecc_next = cfgWrData[`NEP_CFG_ECC_BIT];
		end
		// (RULE_17) clear on reset or read start
		if (cmdReset || readStart) begin
			result_next = `NEP_RES_CLEAN;
		end
		// Completion wins over a clear in the same cycle
		if (finish && opRead_reg && opEcc_reg) begin
			if (uncorr_next) begin
				// (RULE_12) uncorrectable code
				result_next = `NEP_RES_UNCORR;
			end else if (worst_next == 4'h0) begin
				result_next = `NEP_RES_CLEAN;
			end else if (worst_next <= `NEP_LOW_MAX) begin
				// (RULE_11) graded by worst sector
				result_next = `NEP_RES_LOW;
			end else if (worst_next <= `NEP_MID_MAX) begin
				result_next = `NEP_RES_MID;
			end else begin
				// (RULE_13) bit 0 set when corrected
				result_next = `NEP_RES_HIGH;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			// (RULE_15) power-up read of row 0
			state_reg   <= ST_LOAD;
			cnt_reg     <= 12'h000;
			phase_reg   <= 1'b0;
			sector_reg  <= 2'h0;
			pos_reg     <= `NEP_FIRST_POS;
			opEcc_reg   <= `NEP_ECC_RESET;
			opRead_reg  <= 1'b1;
			row_reg     <= '0;
			// (RULE_02) ECC on after power up
			ecc_reg     <= `NEP_ECC_RESET;
			result_reg  <= `NEP_RES_CLEAN;
			worst_reg   <= 4'h0;
			uncorr_reg  <= 1'b0;
			stored_reg  <= 88'h0;
			initCnt_reg <= 18'(POWER_UP_WAIT_CYC);
			done_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			phase_reg   <= phase_next;
			sector_reg  <= sector_next;
			pos_reg     <= pos_next;
			opEcc_reg   <= opEcc_next;
			opRead_reg  <= opRead_next;
			row_reg     <= row_next;
			ecc_reg     <= ecc_next;
			result_reg  <= result_next;
			worst_reg   <= worst_next;
			uncorr_reg  <= uncorr_next;
			stored_reg  <= stored_next;
			initCnt_reg <= initCnt_next;
			done_reg    <= done_next;
		end
	end

	// Busy until the initial load and the power-up wait have both ended
	assign busy                 = (state_reg != ST_IDLE) || (initCnt_reg != 18'h0);
	assign opDone               = done_reg;
	assign eccEnable            = ecc_reg;
	// (RULE_18) result in status bits 6 to 4
	assign statusByte           = {1'b0, result_reg, 3'h0, busy};
	assign correctionResultBit2 = result_reg[2];
	assign correctionResultBit1 = result_reg[1];
	assign correctionResultBit0 = result_reg[0];
	assign hostRdData           = memRdData;
	assign arrayRow             = row_reg;
	assign arrayAddr            = cnt_reg;
	assign arrayWrData          = memRdData;
endmodule
`default_nettype wire

/* nep_ecc_engine_props.sv */
// Purpose: Port-level checker for the page ECC engine
// Assumes: One clock domain, synchronous reset
// Notes: Bound to every engine instance
`default_nettype none
module nep_ecc_engine_props #(
	parameter int ROW_W = 17
) (
	// Clock and reset
	input wire logic             core_clk,
	input wire logic             srst,
	// Commands and features
	input wire logic             pageReadReq,
	input wire logic             programReq,
	input wire logic             cmdReset,
	input wire logic             cfgWrEn,
	input wire logic [7:0]       cfgAddr,
	input wire logic [7:0]       cfgWrData,
	// Status
	input wire logic             eccEnable,
	input wire logic [7:0]       statusByte,
	input wire logic             correctionResultBit2,
	input wire logic             correctionResultBit1,
	input wire logic             correctionResultBit0,
	input wire logic             busy,
	input wire logic             opDone,
	// Array side
	input wire logic [ROW_W-1:0] arrayRow,
	input wire logic             arrayRdEn
);
	logic [2:0] res;
	assign res = {correctionResultBit2, correctionResultBit1, correctionResultBit0};
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	AST_PWRUP_ON: assert property ($fell(srst) |-> eccEnable && busy && res == 3'h0)
		else $error("ecc not on with clear result after reset");
	AST_PWRUP_ROW0: assert property ($fell(srst) |-> ##[0:2] (arrayRdEn && arrayRow == '0))
		else $error("power-up load not from row zero");
	AST_ECC_SET: assert property (cfgWrEn && cfgAddr == 8'hB0 && cfgWrData[4] |=> eccEnable)
		else $error("ecc enable write not taken");
	AST_ECC_CLR: assert property (cfgWrEn && cfgAddr == 8'hB0 && !cfgWrData[4] |=> !eccEnable)
		else $error("ecc disable write not taken");
	AST_ECC_OTHER: assert property (cfgWrEn && cfgAddr != 8'hB0 |=> $stable(eccEnable))
		else $error("other feature address changed ecc enable");
	AST_STATUS_MAP: assert property (statusByte[6:4] == res && statusByte[0] == busy)
		else $error("status byte does not mirror result");
	AST_CODE_LEGAL: assert property (!(res[2] && (res[1] || !res[0])))
		else $error("reserved or invalid result code");
	AST_CMD_CLEAR: assert property (cmdReset && !busy |=> res == 3'h0)
		else $error("reset command did not clear result");
	AST_READ_CLEAR: assert property (pageReadReq && !busy |=> (busy && res == 3'h0) [*8])
		else $error("read start did not clear result");
	AST_RESULT_EVENT: assert property ($changed(res) && !$past(cmdReset) && !$past(pageReadReq)
		|-> ##[0:1] opDone)
		else $error("result changed without a finished read");
	AST_TAKE_BUSY: assert property ((pageReadReq || programReq) && !busy |=> busy)
		else $error("request taken without busy");
endmodule
bind nep_ecc_engine nep_ecc_engine_props #(.ROW_W(ROW_W)) u_props (.core_clk, .srst, .pageReadReq,
	.programReq, .cmdReset, .cfgWrEn, .cfgAddr, .cfgWrData, .eccEnable, .statusByte, .correctionResultBit2,
	.correctionResultBit1, .correctionResultBit0, .busy, .opDone, .arrayRow, .arrayRdEn);
`default_nettype wire

/* nep_array_model.sv */
// Purpose: Array behind the engine: bytes per row and column, read data one cycle late
// Assumes: Unwritten bytes read 00h, an all-zero page is a clean code word
// Notes: Idle data line toggles so a stale byte is never mistaken for an answer
`default_nettype none
module nep_array_model #(
	parameter int ROW_W = 17
) (
	// Clock
	input  wire logic              core_clk,
	// Array port
	input  wire logic [ROW_W-1:0]  arrayRow,
	input  wire nep_pkg::nep_col_t arrayAddr,
	input  wire logic              arrayRdEn,
	output logic      [7:0]        arrayRdData,
	input  wire logic              arrayWrEn,
	input  wire logic [7:0]        arrayWrData
);
	import nep_pkg::*;
	logic [7:0] mem [int];
	function automatic logic [7:0] peek(int row, int col);
		return mem.exists(row * 4096 + col) ? mem[row * 4096 + col] : 8'h00;
	endfunction
	task automatic flip(int row, int col, int b);
		mem[row * 4096 + col] = peek(row, col) ^ (8'h01 << b);
	endtask
	always @(posedge core_clk) begin
		if (arrayRdEn) begin
			arrayRdData <= peek(int'(arrayRow), int'(arrayAddr));
		end else begin
			arrayRdData <= ~arrayRdData;
		end
		if (arrayWrEn) begin
			mem[int'(arrayRow) * 4096 + int'(arrayAddr)] = arrayWrData;
		end
	end
endmodule
`default_nettype wire

/* tb_nep_ecc_engine.sv */
// Purpose: Self-checking bench for the page ECC engine
// Assumes: Shortened power-up wait, array model on the array port
// Notes: Bit errors are injected in the array copy, one lane each unless stated
`default_nettype none
`include "nep_map.svh"
module tb_nep_ecc_engine;
	timeunit 1ns;
	timeprecision 100ps;
	import nep_pkg::*;
	localparam int ROW_W = 17;
	logic             core_clk = 1'b0;
	logic             srst = 1'b1;
	logic             pageReadReq = 1'b0;
	logic             programReq = 1'b0;
	logic [ROW_W-1:0] pageRow = '0;
	logic             cmdReset = 1'b0;
	logic             cfgWrEn = 1'b0;
	logic [7:0]       cfgAddr = 8'h00;
	logic [7:0]       cfgWrData = 8'h00;
	nep_col_t         hostAddr = '0;
	logic             hostWrEn = 1'b0;
	logic [7:0]       hostWrData = 8'h00;
	logic             eccEnable, correctionResultBit2, correctionResultBit1, correctionResultBit0;
	logic             busy, opDone, arrayRdEn, arrayWrEn;
	logic [7:0]       statusByte, hostRdData, arrayRdData, arrayWrData;
	logic [ROW_W-1:0] arrayRow;
	nep_col_t         arrayAddr;
	int               err_count = 0;
	int               compares = 0;
	nep_ecc_engine #(.ROW_W(ROW_W), .POWER_UP_WAIT_CYC(20)) u_dut (.core_clk, .srst, .pageReadReq, .programReq,
		.pageRow, .cmdReset, .cfgWrEn, .cfgAddr, .cfgWrData, .eccEnable, .statusByte, .correctionResultBit2,
		.correctionResultBit1, .correctionResultBit0, .busy, .opDone, .hostAddr, .hostWrEn, .hostWrData,
		.hostRdData, .arrayRow, .arrayAddr, .arrayRdEn, .arrayRdData, .arrayWrEn, .arrayWrData);
	nep_array_model #(.ROW_W(ROW_W)) u_arr (.core_clk, .arrayRow, .arrayAddr, .arrayRdEn, .arrayRdData,
		.arrayWrEn, .arrayWrData);
	always #5 core_clk = ~core_clk;
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (err_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] pat(int col);
		return 8'(col * 7 + 3);
	endfunction
	task automatic tick(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic waitIdle();
		for (int n = 0; n < 20000 && busy !== 1'b0; n++) tick();
		check("idle", busy, 1'b0);
	endtask
	task automatic checkRes(logic [2:0] exp);
		check("result", {correctionResultBit2, correctionResultBit1, correctionResultBit0}, exp);
		check("status result", statusByte[6:4], exp);
	endtask
	task automatic startOp(logic rd);
		pageRow = 17'h5;
		pageReadReq = rd;
		programReq = !rd;
		tick();
		pageReadReq = 1'b0;
		programReq = 1'b0;
		check("busy", busy, 1'b1);
		waitIdle();
	endtask
	task automatic readCache(int col, output logic [7:0] v);
		hostAddr = 12'(col);
		tick(2);
		v = hostRdData;
	endtask
	task automatic cfgWrite(logic [7:0] a, logic [7:0] d);
		cfgWrEn = 1'b1;
		cfgAddr = a;
		cfgWrData = d;
		tick();
		cfgWrEn = 1'b0;
		tick();
	endtask
	task automatic pulseReset();
		cmdReset = 1'b1;
		tick();
		cmdReset = 1'b0;
	endtask
	task automatic t_powerup();
		tick();
		check("ecc on", eccEnable, 1'b1);
		check("load row", arrayRow, '0);
		waitIdle();
		checkRes(`NEP_RES_CLEAN);
	endtask
	task automatic t_program();
		logic [7:0] orAll;
		for (int c = 0; c < 'h840; c++) begin
			hostAddr = 12'(c);
			hostWrEn = 1'b1;
			hostWrData = pat(c);
			tick();
		end
		hostWrEn = 1'b0;
		startOp(1'b0);
		for (int c = 0; c < 'h840; c++) check("stored byte", u_arr.peek(5, c), pat(c));
		for (int s = 0; s < 4; s++) begin
			orAll = 8'h00;
			for (int b = 0; b < 11; b++) orAll |= u_arr.peek(5, 'h840 + 16 * s + b);
			check("parity present", orAll != 8'h00, 1'b1);
			for (int b = 11; b < 16; b++) check("parity pad", u_arr.peek(5, 'h840 + 16 * s + b), 8'h00);
		end
	endtask
	task automatic readErr(int sec, int k, bit oneLane, logic [2:0] exp);
		int cols[8];
		logic [7:0] v;
		for (int i = 0; i < k; i++) begin
			cols[i] = (i == k - 1) ? 'h800 + 16 * sec + 5 : sec * 512 + 61 * i;
			u_arr.flip(5, cols[i], oneLane ? 0 : i);
		end
		startOp(1'b1);
		checkRes(exp);
		for (int i = 0; i < k; i++) begin
			if (exp != `NEP_RES_UNCORR) begin
				readCache(cols[i], v);
				check("corrected byte", v, pat(cols[i]));
			end
			u_arr.flip(5, cols[i], oneLane ? 0 : i);
		end
	endtask
	task automatic t_reads();
		readErr(1, 3, 1'b0, `NEP_RES_LOW);
		readErr(2, 4, 1'b0, `NEP_RES_MID);
		readErr(0, 7, 1'b0, `NEP_RES_HIGH);
		readErr(1, 8, 1'b0, `NEP_RES_HIGH);
		readErr(3, 2, 1'b1, `NEP_RES_UNCORR);
		pulseReset();
		checkRes(`NEP_RES_CLEAN);
		check("ecc kept", eccEnable, 1'b1);
	endtask
	task automatic t_eccOff();
		logic [7:0] v;
		cfgWrite(8'hB1, 8'h00);
		check("ecc other addr", eccEnable, 1'b1);
		cfgWrite(8'hB0, 8'h00);
		check("ecc off", eccEnable, 1'b0);
		pulseReset();
		u_arr.flip(5, 'h100, 0);
		startOp(1'b1);
		checkRes(`NEP_RES_CLEAN);
		readCache('h100, v);
		check("raw byte", v, pat('h100) ^ 8'h01);
		startOp(1'b0);
		check("raw store", u_arr.peek(5, 'h100), pat('h100) ^ 8'h01);
		u_arr.flip(5, 'h100, 0);
		cfgWrite(8'hB0, 8'h10);
		check("ecc back on", eccEnable, 1'b1);
	endtask
	initial begin
		tick(6);
		srst = 1'b0;
		t_powerup();
		t_program();
		t_reads();
		t_eccOff();
		end_of_test();
	end
	initial begin
		#1000us;
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
